// >>> rtl/pcdr_pkg.sv
// Package of constants for the preamble impulse response diagnostic register group.
//
// Overview of operation
// RULE_01 - Channel area, 17 unsigned bits, sits at bits 16:0 of offset 0x2C.
// RULE_02 - Magnitude one sample after first path, 22 bits, offset 0x30.
// RULE_03 - Magnitude two samples after first path, 22 bits, offset 0x34.
// RULE_04 - Bits above each field are reserved and read as zero.
// RULE_05 - Registers update after analysis only while minimal diagnostics bit is clear.
// RULE_06 - Values are valid once analysis complete flag is set; software waits. The flag also sets while the minimal bit is set, beside held old values.
// RULE_07 - All three registers are 32-bit read-only; writes change nothing.
// RULE_08 - Values hold until next qualifying analysis; reads have no side effect.
package pcdr_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int          ADDR_W                     = 8;
   localparam int          DATA_W                     = 32;
   localparam logic [7:0]  OFS_PREAMBLE_CHANNEL_AREA  = 8'h2C;
   localparam logic [7:0]  OFS_FIRST_PATH_PLUS_ONE    = 8'h30;
   localparam logic [7:0]  OFS_FIRST_PATH_PLUS_TWO    = 8'h34;
   localparam logic [7:0]  OFS_ANALYSIS_STATUS        = 8'h3C;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int          AREA_W                     = 17;
   localparam int          MAG_W                      = 22;
   localparam int          STATUS_DONE_BIT            = 0;
   localparam int          STATUS_MINIMAL_DIAGNOSTICS_BIT_BIT         = 1;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [16:0] RST_AREA                   = 17'h00000;
   localparam logic [21:0] RST_MAG                    = 22'h000000;
   localparam logic [31:0] RST_RDATA                  = 32'h00000000;

endpackage : pcdr_pkg

// >>> rtl/pcdr_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module pcdr_sync
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;
endmodule : pcdr_sync
`default_nettype wire

// >>> rtl/pcdr_capture.sv
// Holding register for one diagnostic field, loaded on a qualified strobe.
`timescale 1ns/1ns
`default_nettype none
module pcdr_capture
#(
   parameter int W = 22
)
(
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst_n,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_value,
   output logic      [W-1:0] o_value
);
   logic [W-1:0] value_ff;
   logic [W-1:0] nxt_value;

   always_comb
   begin
      nxt_value = value_ff;
      if (i_load)
      begin
         nxt_value = i_value; // RULE_08
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         value_ff <= '0;
      end
      else
      begin
         value_ff <= nxt_value;
      end
   end

   assign o_value = value_ff;
endmodule : pcdr_capture
`default_nettype wire

// >>> rtl/pcdr_regs.sv
// Top of the preamble impulse response diagnostic register group.
`timescale 1ns/1ns
`default_nettype none
module pcdr_regs
(
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_rst_n,
   // Host register port.
   input  wire logic [pcdr_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [pcdr_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [pcdr_pkg::DATA_W-1:0] o_rdata,
   // Analyser result port, same clock.
   input  wire logic                        i_result_valid,
   input  wire logic [pcdr_pkg::AREA_W-1:0] i_channel_area_value,
   input  wire logic [pcdr_pkg::MAG_W-1:0]  i_fp_next_sample_mag,
   input  wire logic [pcdr_pkg::MAG_W-1:0]  i_fp_second_sample_mag,
   input  wire logic                        i_analysis_start,
   // Configuration bit from the analyser configuration register.
   input  wire logic                        i_minimal_diagnostics_bit,
   output logic                             o_analysis_complete_flag
);

   // ----------------------------------------------------------------------
   // Configuration crossing
   // ----------------------------------------------------------------------
   // The configuration bit may come from a block on another clock, so it is
   // synchronised; its value matters at the analysis result strobe and in bit 1 of the status word.
   logic minimal_diagnostics_bit_sync;

   pcdr_sync u_sync
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_minimal_diagnostics_bit),
      .o_sync    (minimal_diagnostics_bit_sync)
   );

   // ----------------------------------------------------------------------
   // Capture of analysis results
   // ----------------------------------------------------------------------
   logic                        load_results;
   logic [pcdr_pkg::AREA_W-1:0] area_q;
   logic [pcdr_pkg::MAG_W-1:0]  mag1_q;
   logic [pcdr_pkg::MAG_W-1:0]  mag2_q;

   assign load_results = i_result_valid && !minimal_diagnostics_bit_sync; // RULE_05

   pcdr_capture #(.W(pcdr_pkg::AREA_W)) u_area
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_load    (load_results),
      .i_value   (i_channel_area_value),
      .o_value   (area_q)
   );

   pcdr_capture #(.W(pcdr_pkg::MAG_W)) u_mag1
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_load    (load_results),
      .i_value   (i_fp_next_sample_mag),
      .o_value   (mag1_q)
   );

   pcdr_capture #(.W(pcdr_pkg::MAG_W)) u_mag2
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_load    (load_results),
      .i_value   (i_fp_second_sample_mag),
      .o_value   (mag2_q)
   );

   // ----------------------------------------------------------------------
   // Analysis complete flag
   // ----------------------------------------------------------------------
   // The flag rises on every result strobe, but the fields load in that edge only
   // while the synchronised minimal bit is clear, so a set flag may sit beside old
   // values. A new analysis start clears it; a result in the same cycle as a start wins.
   logic done_ff;
   logic nxt_done;

   always_comb
   begin
      nxt_done = done_ff;
      if (i_analysis_start)
      begin
         nxt_done = 1'b0;
      end
      if (i_result_valid)
      begin
         nxt_done = 1'b1; // RULE_06
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= nxt_done;
      end
   end

   assign o_analysis_complete_flag = done_ff;

   // ----------------------------------------------------------------------
   // Read word packing
   // ----------------------------------------------------------------------
   // Reserved bits above each field are forced to zero in one place, so a
   // change of field width touches only the width constant of the package.
   function automatic logic [pcdr_pkg::DATA_W-1:0] pack_area
   (
      input logic [pcdr_pkg::AREA_W-1:0] field
   );
      logic [pcdr_pkg::DATA_W-1:0] word;
      word                       = '0;
      word[pcdr_pkg::AREA_W-1:0] = field; // RULE_04
      return word;
   endfunction : pack_area

   function automatic logic [pcdr_pkg::DATA_W-1:0] pack_mag
   (
      input logic [pcdr_pkg::MAG_W-1:0] field
   );
      logic [pcdr_pkg::DATA_W-1:0] word;
      word                      = '0;
      word[pcdr_pkg::MAG_W-1:0] = field; // RULE_04
      return word;
   endfunction : pack_mag

   function automatic logic [pcdr_pkg::DATA_W-1:0] pack_status
   (
      input logic done,
      input logic minimal
   );
      logic [pcdr_pkg::DATA_W-1:0] word;
      word                               = '0;
      word[pcdr_pkg::STATUS_DONE_BIT]    = done;
      word[pcdr_pkg::STATUS_MINIMAL_DIAGNOSTICS_BIT_BIT] = minimal;
      return word;
   endfunction : pack_status

   // ----------------------------------------------------------------------
   // Register words
   // ----------------------------------------------------------------------
   logic [pcdr_pkg::DATA_W-1:0] word_area;
   logic [pcdr_pkg::DATA_W-1:0] word_mag1;
   logic [pcdr_pkg::DATA_W-1:0] word_mag2;
   logic [pcdr_pkg::DATA_W-1:0] word_status;

   assign word_area   = pack_area(area_q); // RULE_01
   assign word_mag1   = pack_mag(mag1_q); // RULE_02
   assign word_mag2   = pack_mag(mag2_q); // RULE_03
   assign word_status = pack_status(done_ff, minimal_diagnostics_bit_sync);

   // ----------------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------------
   // Writes are accepted and ignored: every register here is read-only.
   logic [pcdr_pkg::DATA_W-1:0] rdata_ff;
   logic [pcdr_pkg::DATA_W-1:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = pcdr_pkg::RST_RDATA;
      if (i_rd)
      begin
         unique case (i_addr)
            pcdr_pkg::OFS_PREAMBLE_CHANNEL_AREA:
            begin
               nxt_rdata = word_area; // RULE_01 RULE_04
            end
            pcdr_pkg::OFS_FIRST_PATH_PLUS_ONE:
            begin
               nxt_rdata = word_mag1; // RULE_02 RULE_04
            end
            pcdr_pkg::OFS_FIRST_PATH_PLUS_TWO:
            begin
               nxt_rdata = word_mag2; // RULE_03 RULE_04
            end
            pcdr_pkg::OFS_ANALYSIS_STATUS:
            begin
               nxt_rdata = word_status;
            end
            default:
            begin
               nxt_rdata = pcdr_pkg::RST_RDATA;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_ff <= pcdr_pkg::RST_RDATA;
      end
      else
      begin
         rdata_ff <= nxt_rdata; // RULE_07 RULE_08
      end
   end

   assign o_rdata = rdata_ff;

   // i_wdata and i_wr have no effect by design.
   logic unused_wr;
   assign unused_wr = i_wr ^ (^i_wdata);

endmodule : pcdr_regs
`default_nettype wire

// >>> bench/pcdr_regs_assertions.sv
// Concurrent checks on the diagnostic register group ports.
`timescale 1ns/1ns
`default_nettype none
module pcdr_regs_assertions
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_addr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_result_valid,
   input wire logic [16:0] i_channel_area_value,
   input wire logic [21:0] i_fp_second_sample_mag,
   input wire logic        i_analysis_start,
   input wire logic        i_minimal_diagnostics_bit,
   input wire logic        o_analysis_complete_flag
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   chk_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("idle data");
   chk_area_rsvd: assert property (i_rd && i_addr == 8'h2C |=> o_rdata[31:17] == 15'h0)
      else $error("area reserved");
   chk_mag_rsvd:
      assert property (i_rd && i_addr[7:4] == 4'h3 |=> o_rdata[31:22] == 10'h0)
      else $error("mag reserved");
   // The config bit is seen two edges late, so loads are judged by its value then.
   chk_area_load:
      assert property (i_result_valid && !$past(i_minimal_diagnostics_bit, 2) ##1
         i_rd && i_addr == 8'h2C |=> o_rdata == {15'h0, $past(i_channel_area_value, 2)})
      else $error("area load");
   chk_mag_load:
      assert property (i_result_valid && !$past(i_minimal_diagnostics_bit, 2) ##1
         i_rd && i_addr == 8'h34 |=> o_rdata == {10'h0, $past(i_fp_second_sample_mag, 2)})
      else $error("mag load");
   chk_hold_value:
      assert property (i_rd && i_addr == 8'h30 && !i_result_valid ##1
         i_rd && i_addr == 8'h30 |=> $stable(o_rdata))
      else $error("hold");
   chk_min_block:
      assert property (i_rd && i_addr == 8'h30 && !i_result_valid ##1 i_result_valid &&
         $past(i_minimal_diagnostics_bit, 2) && $past(i_rst_n, 2) ##1
         i_rd && i_addr == 8'h30 |=> o_rdata == $past(o_rdata, 2))
      else $error("minimal load");
   chk_flag_set: assert property (i_result_valid |=> o_analysis_complete_flag)
      else $error("flag");
   chk_flag_clear:
      assert property (i_analysis_start && !i_result_valid |=> !o_analysis_complete_flag)
      else $error("flag clear");
   chk_flag_hold:
      assert property (!i_analysis_start && !i_result_valid |=> $stable(o_analysis_complete_flag))
      else $error("flag hold");
endmodule : pcdr_regs_assertions
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the diagnostic register group.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        i_clk_sys, i_rst_n, i_wr, i_rd, i_result_valid, i_analysis_start, chk_d;
   logic        i_minimal_diagnostics_bit, o_analysis_complete_flag;
   logic        exp_flag, exp_fd;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, exp_n, exp_d;
   logic [16:0] i_channel_area_value;
   logic [21:0] i_fp_next_sample_mag, i_fp_second_sample_mag;
   int          n_errors, n_checks;
   pcdr_regs uut
   (
      .i_clk_sys                 (i_clk_sys),
      .i_rst_n                   (i_rst_n),
      .i_addr                    (i_addr),
      .i_wdata                   (i_wdata),
      .i_wr                      (i_wr),
      .i_rd                      (i_rd),
      .o_rdata                   (o_rdata),
      .i_result_valid            (i_result_valid),
      .i_channel_area_value      (i_channel_area_value),
      .i_fp_next_sample_mag      (i_fp_next_sample_mag),
      .i_fp_second_sample_mag    (i_fp_second_sample_mag),
      .i_analysis_start          (i_analysis_start),
      .i_minimal_diagnostics_bit (i_minimal_diagnostics_bit),
      .o_analysis_complete_flag  (o_analysis_complete_flag)
   );
   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   task summarize;
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask : chk
   task chk_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask : chk_flag
   // Read data is judged half a cycle after it lands, clear of edge races.
   always @(posedge i_clk_sys)
   begin
      chk_d <= i_rd;
      exp_d <= exp_n;
      exp_fd <= exp_flag;
   end
   always @(negedge i_clk_sys)
   begin
      if (chk_d === 1'b1)
         chk(o_rdata, exp_d);
      if (i_rst_n === 1'b1)
         chk_flag(o_analysis_complete_flag, exp_fd);
   end
   task cyc(input logic [3:0] c, input logic [7:0] a, input logic [31:0] e);
      {i_rd, i_wr, i_result_valid, i_analysis_start} <= c;
      i_addr <= a;
      exp_n  <= e;
      @(posedge i_clk_sys);
   endtask : cyc
   task rd(input logic [7:0] a, input logic [31:0] e);
      cyc(4'h8, a, e);
   endtask : rd
   task res(input logic [16:0] ca, input logic [21:0] m1, input logic [21:0] m2);
      i_channel_area_value   <= ca;
      i_fp_next_sample_mag   <= m1;
      i_fp_second_sample_mag <= m2;
      exp_flag               <= 1'b1;
      cyc(4'h2, 8'h00, 32'h0);
   endtask : res
   task begin_analysis;
      exp_flag <= 1'b0;
      cyc(4'h1, 8'h00, 32'h0);
   endtask : begin_analysis
   initial
   begin
      {i_rst_n, i_wr, i_rd, i_result_valid, i_analysis_start} = '0;
      {i_minimal_diagnostics_bit, i_addr, i_wdata, exp_n} = '0;
      exp_flag = 1'b0;
      {i_channel_area_value, i_fp_next_sample_mag, i_fp_second_sample_mag} = '0;
      n_errors = 0;
      n_checks = 0;
      repeat (5) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(8'h2C, 32'h0);
      rd(8'h3C, 32'h0);
      begin_analysis();
      res(17'h1FFFF, 22'h3FFFFF, 22'h2AAAAA);
      rd(8'h2C, 32'h1FFFF);
      rd(8'h30, 32'h3FFFFF);
      rd(8'h30, 32'h3FFFFF);
      rd(8'h34, 32'h2AAAAA);
      rd(8'h3C, 32'h1);
      rd(8'h38, 32'h0);
      i_wdata <= 32'h00A5A5A5;
      for (int k = 0; k < 3; k++)
         cyc(4'h4, 8'h2C + 8'(4 * k), 32'h0);
      rd(8'h2C, 32'h1FFFF);
      rd(8'h30, 32'h3FFFFF);
      rd(8'h34, 32'h2AAAAA);
      i_minimal_diagnostics_bit <= 1'b1;
      repeat (2) cyc(4'h0, 8'h00, 32'h0);
      begin_analysis();
      rd(8'h3C, 32'h2);
      rd(8'h30, 32'h3FFFFF);
      res(17'h00155, 22'h000001, 22'h000002);
      rd(8'h30, 32'h3FFFFF);
      rd(8'h3C, 32'h3);
      i_minimal_diagnostics_bit <= 1'b0;
      repeat (2) cyc(4'h0, 8'h00, 32'h0);
      res(17'h00155, 22'h000001, 22'h000002);
      rd(8'h34, 32'h2);
      rd(8'h30, 32'h1);
      rd(8'h2C, 32'h155);
      // A result beside a start must leave the flag set.
      exp_flag <= 1'b1;
      cyc(4'h3, 8'h00, 32'h0);
      cyc(4'h0, 8'h00, 32'h0);
      i_rst_n  <= 1'b0;
      exp_flag <= 1'b0;
      cyc(4'h0, 8'h00, 32'h0);
      i_rst_n <= 1'b1;
      rd(8'h2C, 32'h0);
      rd(8'h3C, 32'h0);
      cyc(4'h0, 8'h00, 32'h0);
      summarize();
   end
endmodule : tb_top
bind pcdr_regs pcdr_regs_assertions u_chk
(
   .i_clk_sys                 (i_clk_sys),
   .i_rst_n                   (i_rst_n),
   .i_addr                    (i_addr),
   .i_rd                      (i_rd),
   .o_rdata                   (o_rdata),
   .i_result_valid            (i_result_valid),
   .i_channel_area_value      (i_channel_area_value),
   .i_fp_second_sample_mag    (i_fp_second_sample_mag),
   .i_analysis_start          (i_analysis_start),
   .i_minimal_diagnostics_bit (i_minimal_diagnostics_bit),
   .o_analysis_complete_flag  (o_analysis_complete_flag)
);
`default_nettype wire
